// file: logic/dcn_timescale.sv
// Purpose: Time-scale core: loop, epoch synchronizer, exporters, importers, generator reference
// Assumes: Host logic runs on clk_sys; clock and sync pins are asynchronous
// Notes:   Importer depth must be a power of two
`timescale 1ns/1ns

module dcn_fifo
  import dcn_pkg::*;
#(
  parameter int W = TW,
  parameter int D = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                room;
  } dcn_fifo_st_t;

  dcn_fifo_st_t st;
  dcn_fifo_st_t next_st;
  logic         push;
  logic         pop;

  assign in_ready  = st.room;
  assign out_valid = st.cnt != '0;
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid && st.room;
  assign pop       = out_ready && out_valid;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp         = st.wp + AW'(1);
    end
    if (pop) begin
      next_st.rp = st.rp + AW'(1);
    end
    next_st.cnt  = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    next_st.room = next_st.cnt != (AW+1)'(D);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st      <= '0;
      st.room <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule

// Contract
// (R1) The loop locks to the selected reference stamps and keeps a local scale of accumulated reference periods.
// (R2) The loop's closed-loop error is driven out as a correction term for clock compensation.
// (R3) Each clock converter synchronizes a pin, optionally divides it, and stamps every rising edge of the divided signal.
// (R4) Each consumer of stamps picks its source through its own selection multiplexer.
// (R5) The epoch synchronizer stamps the sync input's rising edge and holds it as the trigger.
// (R6) The host writes the trigger's time code and then strobes commit before the next trigger.
// (R7) On commit the scale is offset so the common scale reads the programmed code at the trigger.
// (R8) Each exporter turns its selected stamps into common-scale codes for the host to read.
// (R9) Each importer turns a host series of common-scale codes into internal stamps.
// (R10) There are nine exporters and two importers.
// (R11) The host feeds each importer uniformly increasing codes forming a digital clock signal.
// (R12) All edge stamps use the system clock as their timing basis; the sync-edge trigger is taken from the local scale (local_int) instead.
// (R13) Common-scale stamps from a selected source feed the channel DPLL reference output.
// (R14) With one shared reference the host uses the primary input only.
// (R15) A newer trigger replaces the held one and the commit applies to the newest.
module dcn_timescale
  import dcn_pkg::*;
#(
  parameter int NP = N_PHY,
  parameter int NE = N_EXP,
  parameter int NI = N_IMP
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Pins
  input  wire logic [NP-1:0]          phy_clk_in,
  input  wire logic                   sync_in,
  // Host configuration
  input  wire dcn_cfg_t               cfg,
  input  wire logic [NP-1:0][DW-1:0]  phy_div,
  input  wire logic [NE-1:0][SW-1:0]  exp_sel,
  // Epoch programming
  input  wire dcn_time_t              epoch_code,
  input  wire logic                   epoch_commit,
  // Importer input
  input  wire dcn_code_t [NI-1:0]     imp_in,
  output logic [NI-1:0]               imp_ready,
  // Exporter output
  output dcn_code_t [NE-1:0]          exp_out,
  // Loop and generator outputs
  output logic [CW-1:0]               loop_correction_term,
  output dcn_code_t                   gen_ref
);
  localparam int NS = NP + NI;

  typedef struct packed {
    logic [NP-1:0]           phy_s1;
    logic [NP-1:0]           phy_s2;
    logic [NP-1:0]           phy_prev;
    logic [NP-1:0][DW-1:0]   div_cnt;
    logic                    sync_s1;
    logic                    sync_s2;
    logic                    sync_prev;
    dcn_time_t               sys_count;
    logic [TW+FB-1:0]        local_acc;
    logic [SPW-1:0]          step;
    dcn_time_t               target;
    logic                    started;
    logic [CW-1:0]           corr;
    dcn_time_t               trig;
    dcn_time_t               offset;
    logic [NS-1:0]           src_ev;
    logic [NS-1:0][TW-1:0]   src_ts;
    dcn_code_t [NE-1:0]      exp_out;
    dcn_code_t               gen;
  } dcn_st_t;

  dcn_st_t         st;
  dcn_st_t         next_st;
  dcn_time_t       local_int;
  dcn_time_t       common;
  dcn_time_t       loop_tgt;
  dcn_time_t       loop_err;
  dcn_time_t       epoch_off;
  logic            loop_ev;
  logic [NI-1:0]   imp_valid;
  logic [NI-1:0]   imp_pop;
  dcn_time_t [NI-1:0] imp_head;

  function automatic logic pick(input logic [NS-1:0] ev, input logic [SW-1:0] sel);
    pick = (int'(sel) < NS) ? ev[sel] : 1'b0;
  endfunction

  assign local_int = st.local_acc[TW+FB-1:FB];
  assign common    = local_int + st.offset;
  assign loop_ev   = pick(st.src_ev, cfg.loop_sel);
  assign loop_tgt  = st.target + cfg.ref_period;
  assign loop_err  = loop_tgt - local_int;
  assign epoch_off = epoch_code - st.trig;

  // (R10) two importers
  // (R9) code to stamp
  for (genvar j = 0; j < NI; j++) begin : g_imp
    dcn_fifo #(.W(TW), .D(FIFO_DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (imp_in[j].valid),
      .in_ready  (imp_ready[j]),
      .in_data   (imp_in[j].code),
      .out_valid (imp_valid[j]),
      .out_ready (imp_pop[j]),
      .out_data  (imp_head[j])
    );
    assign imp_pop[j] = imp_valid[j] && ($signed(common - imp_head[j]) >= 0);
  end

  always_comb begin
    next_st           = st;
    next_st.src_ev    = '0;
    // (R12) system clock basis
    next_st.sys_count = st.sys_count + TS_ONE;
    next_st.local_acc = st.local_acc + (TW+FB)'(st.step);
    // (R3) clock converters
    for (int i = 0; i < NP; i++) begin
      next_st.phy_s1[i]   = phy_clk_in[i];
      next_st.phy_s2[i]   = st.phy_s1[i];
      next_st.phy_prev[i] = st.phy_s2[i];
      if (st.phy_s2[i] && !st.phy_prev[i]) begin
        if (st.div_cnt[i] + DIV_STEP >= phy_div[i]) begin
          next_st.div_cnt[i] = '0;
          next_st.src_ev[i]  = 1'b1;
          next_st.src_ts[i]  = st.sys_count;
        end else begin
          next_st.div_cnt[i] = st.div_cnt[i] + DIV_STEP;
        end
      end
    end
    for (int j = 0; j < NI; j++) begin
      if (imp_pop[j]) begin
        next_st.src_ev[NP+j] = 1'b1;
        next_st.src_ts[NP+j] = st.sys_count;
      end
    end
    // (R1) lock scale to reference
    // (R2) correction term out
    if (loop_ev) begin
      if (!st.started) begin
        next_st.started = 1'b1;
        next_st.target  = local_int;
      end else begin
        next_st.target = loop_tgt;
        next_st.step   = st.step + SPW'(loop_err);
        next_st.corr   = CW'(loop_err);
      end
    end
    // (R5) trigger capture
    // (R15) newest trigger wins
    next_st.sync_s1   = sync_in;
    next_st.sync_s2   = st.sync_s1;
    next_st.sync_prev = st.sync_s2;
    if (st.sync_s2 && !st.sync_prev) begin
      next_st.trig = local_int;
    end
    // (R7) epoch alignment
    if (epoch_commit) begin
      next_st.offset = epoch_off;
    end
    // (R8) exporters
    // (R4) source selection
    for (int k = 0; k < NE; k++) begin
      next_st.exp_out[k].valid = pick(st.src_ev, exp_sel[k]);
      if (next_st.exp_out[k].valid) begin
        next_st.exp_out[k].code = common;
      end
    end
    // (R13) generator reference
    next_st.gen.valid = pick(st.src_ev, cfg.gen_sel);
    if (next_st.gen.valid) begin
      next_st.gen.code = common;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st      <= '0;
      st.step <= STEP_NOM;
    end else begin
      st <= next_st;
    end
  end

  assign exp_out              = st.exp_out;
  assign loop_correction_term = st.corr;
  assign gen_ref              = st.gen;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence seq_sync_edge;
    st.sync_s2 && !st.sync_prev;
  endsequence

  sequence seq_loop_ref;
    st.started && loop_ev;
  endsequence

  chk_loop_target: assert property (seq_loop_ref |=> st.target == $past(loop_tgt)) // (R1)
    else $error("loop target did not advance by the reference period");
  chk_corr_term: assert property (seq_loop_ref |=> loop_correction_term == CW'($past(loop_err))) // (R2)
    else $error("correction term does not match loop error");
  chk_phy_stamp: assert property ((st.phy_s2[0] && !st.phy_prev[0] && phy_div[0] <= DIV_ONE) |=> st.src_ev[0]) // (R3)
    else $error("undivided rising edge produced no stamp");
  chk_sel_mux: assert property (exp_out[0].valid |-> $past(exp_sel[0]) != SEL_NONE && $past(|st.src_ev)) // (R4)
    else $error("exporter fired without a selected source event");
  chk_trigger_hold: assert property (seq_sync_edge |=> st.trig == $past(local_int)) // (R5)
    else $error("trigger stamp not captured on sync edge");
  chk_epoch_align: assert property (epoch_commit |=> st.offset == $past(epoch_off)) // (R7)
    else $error("commit did not align common scale to trigger");
  chk_export_code: assert property (exp_out[0].valid |-> exp_out[0].code == $past(common)) // (R8)
    else $error("exported code is not the common scale value");
  chk_import_fire: assert property (imp_pop[0] |=> st.src_ev[NP] && st.src_ts[NP] == $past(st.sys_count)) // (R9)
    else $error("importer pop produced no stamp");
  chk_stamp_basis: assert property (st.src_ev[0] |-> st.src_ts[0] == $past(st.sys_count)) // (R12)
    else $error("stamp not taken from system clock count");
  chk_gen_ref: assert property (gen_ref.valid |-> gen_ref.code == $past(common)) // (R13)
    else $error("generator reference code is not the common scale value");
endmodule

// file: logic/dcn_pkg.sv
// Purpose: Shared types and constants for the digitized clock node time-scale core
// Assumes: 10 MHz system clock, time codes are unsigned nanosecond counts
// Notes:   Source time stamps are system-clock counts, the sync trigger is a local-scale value, time codes are common-scale values
package dcn_pkg;
  localparam int TW            = 48;
  localparam int FB            = 16;
  localparam int SPW           = 32;
  localparam int CW            = 32;
  localparam int SW            = 3;
  localparam int DW            = 8;
  localparam int N_PHY         = 3;
  localparam int N_EXP         = 9;
  localparam int N_IMP         = 2;
  localparam int FIFO_DEPTH    = 4;
  localparam int CLK_HZ        = 10000000;
  localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;

  localparam logic [SPW-1:0] STEP_NOM = SPW'(CLK_PERIOD_NS) << FB;
  localparam logic [SW-1:0]  SEL_NONE = 3'h7;
  localparam logic [DW-1:0]  DIV_ONE  = 8'h01;
  localparam logic [DW-1:0]  DIV_STEP = 8'h01;
  localparam logic [TW-1:0]  TS_ONE   = 48'h0000_0000_0001;

  typedef logic [TW-1:0] dcn_time_t;

  typedef struct packed {
    logic      valid;
    dcn_time_t code;
  } dcn_code_t;

  typedef struct packed {
    dcn_time_t       ref_period;
    logic [SW-1:0]   loop_sel;
    logic [SW-1:0]   gen_sel;
  } dcn_cfg_t;
endpackage

// file: tb/dcn_host_model.sv
// Purpose: Host model feeding one importer with a code series
// Assumes: Codes rise by a fixed step
// Notes:   Holds each word until ready is sampled high
`timescale 1ns/1ns
module dcn_host_model
  import dcn_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Series control
  input  wire logic       start,
  input  wire dcn_time_t  first,
  input  wire dcn_time_t  step,
  input  wire logic [2:0] count,
  // Importer side
  input  wire logic       ready,
  output dcn_code_t       push
);
  logic [2:0] left;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      push <= '0;
      left <= '0;
    end else if (start && left == 3'h0) begin
      push <= '{1'b1, first};
      left <= count;
    end else if (push.valid && ready) begin
      push.code  <= (left == 3'h1) ? ~push.code : push.code + step;
      push.valid <= (left != 3'h1);
      left       <= left - 3'h1;
    end
  end
endmodule

// file: tb/testbench.sv
// Purpose: Self-checking bench for the time-scale core
// Assumes: Local scale runs 100 ns a cycle until the loop is steered
// Notes:   Two host models feed both importers with the same series
`timescale 1ns/1ns
module testbench
  import dcn_pkg::*;
;
  localparam dcn_time_t E = 48'h1000_0000;
  logic              clk_sys = 0;
  logic              rst_n = 0;
  logic [2:0]        phy_clk_in = '0;
  logic              sync_in = 0;
  dcn_cfg_t          cfg = '{48'h0, SEL_NONE, SEL_NONE};
  logic [2:0][7:0]   phy_div = '0;
  logic [8:0][2:0]   exp_sel = '1;
  dcn_time_t         epoch_code = '0;
  logic              epoch_commit = 0;
  dcn_code_t [1:0]   imp_in;
  logic [1:0]        imp_ready;
  dcn_code_t [8:0]   exp_out;
  logic [31:0]       loop_correction_term;
  dcn_code_t         gen_ref;
  logic              start = 0;
  dcn_time_t         first = '0;
  dcn_code_t         push;
  dcn_code_t         push1;
  int                failures = 0;
  int                checked = 0;
  int                cyc = 0;
  int                pulses[9];
  dcn_time_t         cq0[$], cq3[$], cq4[$], gq[$];
  assign imp_in = {push1, push};
  always #50 clk_sys = ~clk_sys;
  dcn_timescale dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .phy_clk_in(phy_clk_in), .sync_in(sync_in),
    .cfg(cfg), .phy_div(phy_div), .exp_sel(exp_sel), .epoch_code(epoch_code), .epoch_commit(epoch_commit),
    .imp_in(imp_in), .imp_ready(imp_ready), .exp_out(exp_out),
    .loop_correction_term(loop_correction_term), .gen_ref(gen_ref));
  dcn_host_model host_u (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .first(first),
    .step(48'd2000), .count(3'h4), .ready(imp_ready[0]), .push(push));
  dcn_host_model host_v (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .first(first),
    .step(48'd2000), .count(3'h4), .ready(imp_ready[1]), .push(push1));
  always @(negedge clk_sys) begin
    cyc++;
    for (int k = 0; k < 9; k++) if (exp_out[k].valid === 1'b1) pulses[k]++;
    if (exp_out[0].valid === 1'b1) cq0.push_back(exp_out[0].code);
    if (exp_out[3].valid === 1'b1) cq3.push_back(exp_out[3].code);
    if (exp_out[4].valid === 1'b1) cq4.push_back(exp_out[4].code);
    if (gen_ref.valid === 1'b1) gq.push_back(gen_ref.code);
    if (cyc == 3000) begin
      failures++;
      end_sim();
    end
  end
  task automatic check(input string what, input dcn_time_t seen, input dcn_time_t exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pin_edge(input logic [2:0] m);
    phy_clk_in = m;
    tick(2);
    phy_clk_in = '0;
  endtask
  task automatic t_reset();
    check("exp valid", TW'(exp_out[0].valid), 0);
    check("imp ready", TW'(imp_ready), 3);
    check("loop term", TW'(loop_correction_term), 0);
    $display("Test reset done");
  endtask
  task automatic t_fanout();
    exp_sel = '0;
    pulses = '{default: 0};
    pin_edge(3'h1);
    tick(8);
    for (int k = 0; k < 9; k++) check("fanout pulses", TW'(pulses[k]), 1);
    check("fanout code 0", exp_out[0].code, 48'd300);
    check("fanout code 8", exp_out[8].code, 48'd300);
    $display("Test fanout done");
  endtask
  task automatic t_divide();
    exp_sel = '1;
    exp_sel[1] = 3'h1;
    phy_div[1] = 8'h03;
    pulses = '{default: 0};
    repeat (3) begin
      pin_edge(3'h6);
      tick(4);
    end
    check("divided", TW'(pulses[1]), 1);
    check("unselected", TW'(pulses[2]), 0);
    $display("Test divide done");
  endtask
  task automatic t_epoch();
    exp_sel[0] = 3'h0;
    sync_in = 1;
    tick(2);
    sync_in = 0;
    tick(28);
    sync_in = 1;
    tick(2);
    sync_in = 0;
    tick(3);
    epoch_code = E;
    epoch_commit = 1;
    tick(1);
    epoch_commit = 0;
    tick(4);
    cq0.delete();
    pin_edge(3'h1);
    tick(18);
    pin_edge(3'h1);
    tick(8);
    check("edges", TW'(cq0.size()), 2);
    check("epoch", TW'(cq0[0] >= E + 900 && cq0[0] <= E + 1200), 1);
    check("scale step", cq0[1] - cq0[0], 48'd2000);
    $display("Test epoch done");
  endtask
  task automatic t_import();
    dcn_time_t due;
    exp_sel[3] = 3'h3;
    exp_sel[4] = 3'h4;
    cfg.gen_sel = 3'h3;
    cq3.delete();
    cq4.delete();
    gq.delete();
    first = cq0[1] + 48'd3000;
    start = 1;
    tick(1);
    start = 0;
    tick(6);
    check("fifo full", TW'(imp_ready), 0);
    tick(120);
    check("imported", TW'(cq3.size()), 4);
    check("imported 1", TW'(cq4.size()), 4);
    for (int i = 0; i < 4; i++) begin
      due = first + TW'(2000 * i);
      check("import code", TW'(cq3[i] >= due && cq3[i] <= due + 300), 1);
      check("import 1 code", TW'(cq4[i] >= due && cq4[i] <= due + 300), 1);
      check("gen code", gq[i], cq3[i]);
    end
    check("fifo drained", TW'(imp_ready), 3);
    $display("Test import done");
  endtask
  task automatic t_loop();
    cfg.ref_period = 48'd2000;
    cfg.loop_sel = 3'h0;
    repeat (4) begin
      pin_edge(3'h1);
      tick(18);
    end
    check("loop locked", TW'(loop_correction_term), 0);
    cfg.ref_period = 48'd2050;
    pin_edge(3'h1);
    tick(6);
    check("loop error", TW'(loop_correction_term), 48'd50);
    $display("Test loop done");
  endtask
  task automatic end_sim();
    $display("Counts: %0d checked, %0d failures", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    tick(20);
    rst_n = 1;
    t_reset();
    t_fanout();
    t_divide();
    t_epoch();
    t_import();
    t_loop();
    end_sim();
  end
endmodule
